// File: inc/mie_pkg.sv
// Purpose: shared constants and types of the instruction execute block
// Assumes: 8-bit datapath, registers reached over APB with 32-bit data
// Notes:   opcodes, offsets and storage sizes are local to this block
`default_nettype none
package mie_pkg;
	// Datapath and storage sizes
	localparam int unsigned DW     = 8;
	localparam int unsigned PCW    = 16;
	localparam int unsigned FLW    = 6;
	localparam int unsigned MEM_N  = 16;
	localparam int unsigned MEM_IW = 4;
	localparam int unsigned STK_N  = 4;
	localparam int unsigned STK_PW = 2;
	localparam int unsigned STK_CW = 3;
	localparam int unsigned OPW    = 5;
	localparam int unsigned IW     = OPW + DW;
	// Register byte offsets
	localparam logic [7:0] OFS_INSTR  = 8'h00;
	localparam logic [7:0] OFS_ACC    = 8'h04;
	localparam logic [7:0] OFS_FLAGS  = 8'h08;
	localparam logic [7:0] OFS_PC     = 8'h0c;
	localparam logic [7:0] OFS_GIE    = 8'h10;
	localparam logic [7:0] OFS_STACK  = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [1:0] MEM_SEL    = 2'h1;
	// Flag bit positions
	localparam int unsigned FL_C   = 0;
	localparam int unsigned FL_AC  = 1;
	localparam int unsigned FL_Z   = 2;
	localparam int unsigned FL_OV  = 3;
	localparam int unsigned FL_PDF = 4;
	localparam int unsigned FL_TO  = 5;
	// Status bit positions
	localparam int unsigned SB_SKIP = 0;
	localparam int unsigned SB_ILL  = 1;
	localparam int unsigned SB_CYC  = 2;
	localparam int unsigned SB_DEP  = 4;
	// Reset values and step counts
	localparam logic [DW-1:0]  ACC_RST  = 8'h00;
	localparam logic [FLW-1:0] FLG_RST  = 6'h00;
	localparam logic [PCW-1:0] PC_RST   = 16'h0000;
	localparam logic [IW-1:0]  INS_RST  = 13'h0000;
	localparam logic           GIE_RST  = 1'b0;
	localparam logic [PCW-1:0] PC_STEP  = 16'h0001;
	localparam logic [PCW-1:0] PC_SKIP  = 16'h0002;
	localparam logic [1:0]     CYC_ONE  = 2'h1;
	localparam logic [1:0]     CYC_TWO  = 2'h2;
	// Instruction codes
	typedef enum logic [4:0] {
		OP_COPY_MEM_TO_ACC  = 5'h00,
		OP_COPY_IMM_TO_ACC  = 5'h01,
		OP_COPY_ACC_TO_MEM  = 5'h02,
		OP_IDLE             = 5'h03,
		OP_OR_MEM           = 5'h04,
		OP_OR_IMM           = 5'h05,
		OP_OR_INTO_MEMORY   = 5'h06,
		OP_SUBROUTINE_EXIT  = 5'h07,
		OP_EXIT_WITH_CONST  = 5'h08,
		OP_INTERRUPT_EXIT   = 5'h09,
		OP_ROT_LEFT         = 5'h0a,
		OP_ROT_LEFT_ACC     = 5'h0b,
		OP_ROT_LEFT_VC      = 5'h0c,
		OP_ROT_LEFT_VC_ACC  = 5'h0d,
		OP_ROT_RIGHT        = 5'h0e,
		OP_ROT_RIGHT_ACC    = 5'h0f,
		OP_ROT_RIGHT_VC     = 5'h10,
		OP_ROT_RIGHT_VC_ACC = 5'h11,
		OP_SUB_BORROW       = 5'h12,
		OP_SUB_BORROW_MEM   = 5'h13,
		OP_DEC_SKIP_ZERO    = 5'h14
	} mie_op_t;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_EXEC  = 2'b01,
		ST_DUMMY = 2'b10,
		ST_DONE  = 2'b11
	} mie_state_t;
endpackage
`default_nettype wire

// File: hdl/mie_alu.sv
// Purpose: combinational result and flag logic of the execute block
// Assumes: operands settled from registers in the same cycle
// Notes:   half carry and overflow are valid only for subtracts
`default_nettype none
module mie_alu (
	input  wire mie_pkg::mie_op_t    op,
	input  wire logic [mie_pkg::DW-1:0] acc,
	input  wire logic [mie_pkg::DW-1:0] mem,
	input  wire logic [mie_pkg::DW-1:0] imm,
	input  wire logic                c_in,
	output logic      [mie_pkg::DW-1:0] res,
	output logic                     c_out,
	output logic                     ac_out,
	output logic                     ov_out
);
	import mie_pkg::*;
	logic [DW:0] sum;
	logic [4:0]  low;
	// Result per opcode
	always_comb begin
		sum    = {1'b0, acc} + {1'b0, ~mem} + {8'h00, c_in};
		low    = {1'b0, acc[3:0]} + {1'b0, ~mem[3:0]} + {4'h0, c_in};
		res    = mem;
		c_out  = c_in;
		ac_out = 1'b0;
		ov_out = 1'b0;
		unique case (op)
			OP_OR_MEM, OP_OR_INTO_MEMORY: res = acc | mem; // [RQ5] [RQ6]
			OP_OR_IMM: res = acc | imm; // [RQ5]
			OP_ROT_LEFT, OP_ROT_LEFT_ACC: begin
				res = {mem[6:0], mem[7]}; // [RQ10]
			end
			OP_ROT_LEFT_VC, OP_ROT_LEFT_VC_ACC: begin
				res   = {mem[6:0], c_in}; // [RQ12]
				c_out = mem[7]; // [RQ12]
			end
			OP_ROT_RIGHT, OP_ROT_RIGHT_ACC: begin
				res = {mem[0], mem[7:1]}; // [RQ13]
			end
			OP_ROT_RIGHT_VC, OP_ROT_RIGHT_VC_ACC: begin
				res   = {c_in, mem[7:1]}; // [RQ14]
				c_out = mem[0]; // [RQ14]
			end
			OP_SUB_BORROW, OP_SUB_BORROW_MEM: begin
				res    = sum[DW-1:0]; // [RQ15]
				c_out  = sum[DW]; // [RQ15]
				ac_out = low[4]; // [RQ15]
				ov_out = (acc[7] != mem[7]) && (sum[7] != acc[7]);
			end
			OP_DEC_SKIP_ZERO: res = mem - 8'h01; // [RQ17]
			default: res = mem;
		endcase
	end
endmodule
`default_nettype wire

// File: hdl/mie_stack.sv
// Purpose: return address stack of the execute block
// Assumes: push and pop never in the same cycle
// Notes:   pointer wraps, so overflow overwrites the oldest entry
`default_nettype none
module mie_stack (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    push,
	input  wire logic                    pop,
	input  wire logic [mie_pkg::PCW-1:0] push_data,
	output logic      [mie_pkg::PCW-1:0] top,
	output logic   [mie_pkg::STK_CW-1:0] depth
);
	import mie_pkg::*;
	localparam logic [STK_PW-1:0] P_ONE = 2'h1;
	localparam logic [STK_CW-1:0] C_ONE = 3'h1;
	localparam logic [STK_CW-1:0] C_MAX = 3'h4;
	typedef struct packed {
		logic [STK_PW-1:0]         ptr;
		logic [STK_CW-1:0]         cnt;
		logic [STK_N-1:0][PCW-1:0] ent;
	} mie_stk_t;
	mie_stk_t q;
	mie_stk_t d;
	// Push writes at the pointer, pop steps it back
	always_comb begin
		d = q;
		if (push) begin
			d.ent[q.ptr] = push_data;
			d.ptr        = q.ptr + P_ONE;
			if (q.cnt != C_MAX)
				d.cnt = q.cnt + C_ONE;
		end else if (pop) begin
			d.ptr = q.ptr - P_ONE;
			if (q.cnt != 3'h0)
				d.cnt = q.cnt - C_ONE;
		end
	end
	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end
	assign top   = q.ent[q.ptr - P_ONE];
	assign depth = q.cnt;
endmodule
`default_nettype wire

// File: hdl/mie_top.sv
// Purpose: execute unit for moves, OR, returns, rotates, subtract
//          with borrow and decrement-skip, behind an APB slave
// Assumes: one APB master; clk at 50 MHz; one instruction per write
// Notes:   writing the instruction register runs it; pready rises
//          when the last machine cycle of the instruction is over
//          Byte offsets: 00 instruction word, 04 accumulator,
//          08 flags, 0c program counter, 10 global interrupt enable,
//          14 stack (a write pushes, a read shows the top), 18 status,
//          data memory bytes at 40 plus four times the index
//          Instruction word: opcode in [12:8], operand in [7:0]; a
//          memory operand takes its index from bits [3:0]
//          Flags: 0 carry, 1 half carry, 2 zero, 3 overflow, 4 and 5
//          are stored only; status: 0 skip taken, 1 unknown opcode,
//          [3:2] cycles of the last instruction, [6:4] stack depth
// Contract
// RQ1: Copy memory byte to accumulator, flags untouched.
// RQ2: Immediate copy loads the 8-bit constant into accumulator, no flags.
// RQ3: Store accumulator into addressed memory byte, flags untouched.
// RQ4: Idle instruction only advances program counter by one.
// RQ5: OR accumulator with memory or constant into accumulator, only zero.
// RQ6: OR-into-memory writes the OR back to memory, only zero flag.
// RQ7: Subroutine exit pops program counter, two cycles, no flags.
// RQ8: Exit with constant pops program counter and loads accumulator.
// RQ9: Interrupt exit pops program counter and sets global enable.
// RQ10: Left rotate moves bit 7 into bit 0, no flags.
// RQ11: Accumulator rotates write accumulator, memory stays unchanged.
// RQ12: Left via carry: old carry to bit 0, bit 7 to carry.
// RQ13: Right rotate moves bit 0 into bit 7, no flags.
// RQ14: Right via carry: bit 0 to carry, old carry to bit 7.
// RQ15: Subtract with borrow: acc plus inverted byte plus carry, four flags.
// RQ16: Memory form of subtract with borrow writes result to memory.
// RQ17: Decrement-skip writes back; zero result discards prefetch, two cycles.
// RQ18: All other instructions here take one machine cycle.
//
// The APB slave port and the register offsets were left to the implementer.
`default_nettype none
module mie_top (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	output logic      [mie_pkg::DW-1:0]  acc,
	output logic      [mie_pkg::FLW-1:0] flags,
	output logic      [mie_pkg::PCW-1:0] pc,
	output logic                         global_interrupt_enable
);
	import mie_pkg::*;

	// State of the execute unit apart from the return stack
	typedef struct packed {
		mie_state_t                st;
		logic [IW-1:0]             instr;
		logic [DW-1:0]             acc;
		logic [FLW-1:0]            flg;
		logic [PCW-1:0]            pc;
		logic                      gie;
		logic [MEM_N-1:0][DW-1:0]  mem;
		logic                      skip;
		logic                      ill;
		logic [1:0]                cyc;
		logic                      rdy;
		logic                      err;
		logic [31:0]               rdata;
	} mie_core_t;

	mie_core_t            q;
	mie_core_t            d;
	logic [1:0]           rst_sync_q;
	logic                 rst_n;
	mie_op_t              op;
	logic [DW-1:0]        opnd;
	logic [MEM_IW-1:0]    midx;
	logic [MEM_IW-1:0]    aidx;
	logic [DW-1:0]        mval;
	logic                 is_mem;
	logic                 res_zero;
	logic [DW-1:0]        res;
	logic                 c_res;
	logic                 ac_res;
	logic                 ov_res;
	logic                 push;
	logic                 pop;
	logic [PCW-1:0]       stk_top;
	logic [STK_CW-1:0]    stk_dep;

	// Reset release through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// Instruction fields and operand fetch
	assign op     = mie_op_t'(q.instr[IW-1:DW]);
	assign opnd   = q.instr[DW-1:0];
	assign midx   = opnd[MEM_IW-1:0];
	assign mval   = q.mem[midx];
	assign aidx   = paddr[MEM_IW+1:2];
	assign is_mem = (paddr[7:6] == MEM_SEL) && (paddr[1:0] == 2'h0);

	// Zero test of the result, shared by every zero flag update
	assign res_zero = (res == 8'h00);

	// Result and flag logic of the current opcode
	mie_alu u_alu (
		.op     (op),
		.acc    (q.acc),
		.mem    (mval),
		.imm    (opnd),
		.c_in   (q.flg[FL_C]),
		.res    (res),
		.c_out  (c_res),
		.ac_out (ac_res),
		.ov_out (ov_res)
	);

	// Return stack: pushed over the bus, popped by the three exits
	mie_stack u_stack (
		.clk       (clk),
		.rst_n     (rst_n),
		.push      (push),
		.pop       (pop),
		.push_data (pwdata[PCW-1:0]),
		.top       (stk_top),
		.depth     (stk_dep)
	);

	// Next state: bus access, execute and sequencing
	always_comb begin
		d    = q;
		push = 1'b0;
		pop  = 1'b0;
		unique case (q.st)
			// Idle: take one bus access per transfer
			ST_IDLE: begin
				if (psel && penable) begin
					d.st    = ST_DONE;
					d.rdy   = 1'b1;
					d.err   = 1'b0;
					d.rdata = 32'h0000_0000;
					if (pwrite) begin
						// Register writes
						case (paddr)
							OFS_INSTR: begin
								d.instr = pwdata[IW-1:0];
								d.st    = ST_EXEC;
								d.rdy   = 1'b0;
							end
							OFS_ACC:   d.acc = pwdata[DW-1:0];
							OFS_FLAGS: d.flg = pwdata[FLW-1:0];
							OFS_PC:    d.pc  = pwdata[PCW-1:0];
							OFS_GIE:   d.gie = pwdata[0];
							// Stack write pushes the low half word
							OFS_STACK: push  = 1'b1;
							// Status is read only; the write is dropped quietly
							OFS_STATUS: begin
								d.err = 1'b0; // Read only
							end
							// Unmapped or misaligned writes answer with an error
							default: begin
								if (is_mem)
									d.mem[aidx] = pwdata[DW-1:0];
								else
									d.err = 1'b1;
							end
						endcase
					end else begin
						// Register reads, narrow data in low bits
						case (paddr)
							OFS_INSTR: d.rdata[IW-1:0]   = q.instr;
							OFS_ACC:   d.rdata[DW-1:0]   = q.acc;
							OFS_FLAGS: d.rdata[FLW-1:0]  = q.flg;
							OFS_PC:    d.rdata[PCW-1:0]  = q.pc;
							OFS_GIE:   d.rdata[0]        = q.gie;
							// Stack read shows the top entry without popping
							OFS_STACK: d.rdata[PCW-1:0]  = stk_top;
							OFS_STATUS: begin
								d.rdata[SB_SKIP]           = q.skip;
								d.rdata[SB_ILL]            = q.ill;
								d.rdata[SB_CYC+1:SB_CYC]   = q.cyc;
								d.rdata[SB_DEP+2:SB_DEP]   = stk_dep;
							end
							// Unmapped or misaligned reads give zero and an error
							default: begin
								if (is_mem)
									d.rdata[DW-1:0] = q.mem[aidx];
								else
									d.err = 1'b1;
							end
						endcase
					end
				end
			end

			ST_EXEC: begin
				// Next word is prefetched while this one runs
				d.pc   = q.pc + PC_STEP; // [RQ4] [RQ18]
				d.skip = 1'b0;
				d.ill  = 1'b0;
				d.cyc  = CYC_ONE; // [RQ18]
				unique case (op)
					// Copy a memory byte into the accumulator
					OP_COPY_MEM_TO_ACC: begin
						d.acc = mval; // [RQ1]
					end
					// Load the operand byte into the accumulator
					OP_COPY_IMM_TO_ACC: begin
						d.acc = opnd; // [RQ2]
					end
					// Store the accumulator into the memory byte
					OP_COPY_ACC_TO_MEM: begin
						d.mem[midx] = q.acc; // [RQ3]
					end
					// Nothing but the program counter step
					OP_IDLE: begin
						d.ill = 1'b0; // Only the step above [RQ4]
					end
					// OR into the accumulator, zero flag only
					OP_OR_MEM, OP_OR_IMM: begin
						d.acc       = res; // [RQ5]
						d.flg[FL_Z] = res_zero; // [RQ5]
					end
					// OR written back to the memory byte
					OP_OR_INTO_MEMORY: begin
						d.mem[midx] = res; // [RQ6]
						d.flg[FL_Z] = res_zero; // [RQ6]
					end
					// Plain exit: restore pc, spend a second cycle
					OP_SUBROUTINE_EXIT: begin
						pop   = 1'b1;
						d.pc  = stk_top; // [RQ7]
						d.cyc = CYC_TWO; // [RQ7]
					end
					// Exit that also loads the operand byte
					OP_EXIT_WITH_CONST: begin
						pop   = 1'b1;
						d.pc  = stk_top; // [RQ8]
						d.acc = opnd; // [RQ8]
					end
					// Interrupt exit turns interrupts back on
					OP_INTERRUPT_EXIT: begin
						pop   = 1'b1;
						d.pc  = stk_top; // [RQ9]
						d.gie = 1'b1; // [RQ9]
					end
					// Memory rotates rewrite the source byte
					OP_ROT_LEFT, OP_ROT_RIGHT: begin
						d.mem[midx] = res; // [RQ10] [RQ13]
					end
					// Accumulator rotates leave memory alone
					OP_ROT_LEFT_ACC, OP_ROT_RIGHT_ACC: begin
						d.acc = res; // [RQ11]
					end
					// Rotates via carry into memory
					OP_ROT_LEFT_VC, OP_ROT_RIGHT_VC: begin
						d.mem[midx] = res; // [RQ12] [RQ14]
						d.flg[FL_C] = c_res; // [RQ12] [RQ14]
					end
					// Rotates via carry into the accumulator
					OP_ROT_LEFT_VC_ACC, OP_ROT_RIGHT_VC_ACC: begin
						d.acc       = res; // [RQ11]
						d.flg[FL_C] = c_res; // [RQ12] [RQ14]
					end
					// Subtract with borrow, to accumulator or memory
					OP_SUB_BORROW, OP_SUB_BORROW_MEM: begin
						if (op == OP_SUB_BORROW_MEM)
							d.mem[midx] = res; // [RQ16]
						else
							d.acc = res; // [RQ15]
						d.flg[FL_C]  = c_res; // [RQ15] [RQ16]
						d.flg[FL_AC] = ac_res; // [RQ15]
						d.flg[FL_OV] = ov_res; // [RQ15]
						d.flg[FL_Z]  = res_zero; // [RQ15]
					end
					// Decrement, write back, skip on a zero result
					OP_DEC_SKIP_ZERO: begin
						d.mem[midx] = res; // [RQ17]
						if (res_zero) begin
							// Prefetched word dropped, dummy cycle
							d.pc   = q.pc + PC_SKIP; // [RQ17]
							d.skip = 1'b1;
							d.cyc  = CYC_TWO; // [RQ17]
						end
					end
					// Unknown code: step only, mark it in status
					default: begin
						d.ill = 1'b1; // Unknown code acts as idle
					end
				endcase
				// Two-cycle instructions pass through the dummy state
				if (d.cyc == CYC_TWO) begin
					d.st = ST_DUMMY; // [RQ7] [RQ17]
				end else begin
					d.st  = ST_DONE;
					d.rdy = 1'b1;
				end
			end

			ST_DUMMY: begin
				// Second machine cycle does no work
				d.st  = ST_DONE;
				d.rdy = 1'b1;
			end

			ST_DONE: begin
				// pready seen high this cycle; drop it
				d.st  = ST_IDLE;
				d.rdy = 1'b0;
				d.err = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Fields not named below, memory included, clear to zero
			q       <= '0;
			q.st    <= ST_IDLE;
			q.instr <= INS_RST;
			q.acc   <= ACC_RST;
			q.flg   <= FLG_RST;
			q.pc    <= PC_RST;
			q.gie   <= GIE_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign prdata                  = q.rdata;
	assign pready                  = q.rdy;
	assign pslverr                 = q.err;
	assign acc                     = q.acc;
	assign flags                   = q.flg;
	assign pc                      = q.pc;
	assign global_interrupt_enable = q.gie;
endmodule
`default_nettype wire

// File: sim/mie_top_properties.sv
// Purpose: concurrent checks on the execute block's ports
// Assumes: instruction writes are held until pready, as APB requires
// Notes:   depth-3 history reaches back before the execute cycle
`default_nettype none
module mie_top_properties (
	input wire logic                    clk,
	input wire logic                    rstn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [7:0]              paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic [mie_pkg::DW-1:0]  acc,
	input wire logic [mie_pkg::FLW-1:0] flags,
	input wire logic [mie_pkg::PCW-1:0] pc,
	input wire logic                    global_interrupt_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	import mie_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Instruction write in progress, its finish and its opcode
	logic       ins;
	logic       done;
	logic [4:0] op;
	assign ins  = psel && pwrite && paddr == OFS_INSTR;
	assign done = ins && penable && pready;
	assign op   = pwdata[12:8];
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready held");
	property p_one;
		ins && $rose(penable) && op != 5'h07 && op != 5'h14
			|-> !pready [*2] ##1 pready;
	endproperty
	a_one: assert property (p_one) else $error("bad length");
	property p_two;
		ins && $rose(penable) && op == 5'h07 |-> !pready [*3] ##1 pready;
	endproperty
	a_two: assert property (p_two) else $error("exit length");
	property p_step;
		done && op inside {[5'h00:5'h06], [5'h0a:5'h13]}
			|-> pc == $past(pc) + PC_STEP;
	endproperty
	a_step: assert property (p_step) else $error("pc step");
	property p_idle; done && op == 5'h03 |-> acc == $past(acc, 3); endproperty
	a_idle: assert property (p_idle) else $error("idle acc");
	property p_kept;
		done && op inside {[5'h00:5'h03], [5'h07:5'h0b], 5'h0e, 5'h0f, 5'h14}
			|-> flags == $past(flags, 3);
	endproperty
	a_kept: assert property (p_kept) else $error("flags");
	property p_imm;
		done && op inside {5'h01, 5'h08} |-> acc == pwdata[7:0];
	endproperty
	a_imm: assert property (p_imm) else $error("imm load");
	property p_or;
		done && op == 5'h05 |-> acc == ($past(acc, 3) | pwdata[7:0])
			&& flags[FL_Z] == (acc == 8'h00);
	endproperty
	a_or: assert property (p_or) else $error("or imm");
	property p_gie; done && op == 5'h09 |-> global_interrupt_enable; endproperty
	a_gie: assert property (p_gie) else $error("enable");
endmodule
bind mie_top mie_top_properties i_props (.clk(clk), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.acc(acc), .flags(flags), .pc(pc),
	.global_interrupt_enable(global_interrupt_enable));
`default_nettype wire

// File: sim/mie_apb_host.sv
// Purpose: APB master standing in for software on the register bus
// Assumes: slave answers with pready within twenty access cycles
// Notes:   n returns access cycles, above 20 when the wait ran out
`default_nettype none
module mie_apb_host (
	input  wire logic        clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end
	// Setup, access held until pready, then release at that edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r,
		output logic e, output int n);
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n <= 20);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Purpose: self-checking bench of the execute block over APB
// Assumes: mie_apb_host drives the bus, one transfer at a time
// Notes:   each table row writes at most one place, then reads one place back
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mie_pkg::*;
	typedef struct packed {
		logic        we;
		logic [7:0]  wa;
		logic [31:0] wd;
		logic [7:0]  ra;
		logic [31:0] ex;
	} mie_row_t;
	logic           clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic           global_interrupt_enable, errv;
	logic [7:0]     paddr;
	logic [31:0]    pwdata, prdata, rdv;
	logic [DW-1:0]  acc;
	logic [FLW-1:0] flags;
	logic [PCW-1:0] pc, p;
	int             ncyc, n_errors, checks;
	mie_row_t rows [33] = '{
		'{1'b1, 8'h40, 32'h81, 8'h40, 32'h81},
		'{1'b1, 8'h00, 32'h0000, 8'h04, 32'h81},
		'{1'b1, 8'h00, 32'h0a00, 8'h40, 32'h03},
		'{1'b1, 8'h00, 32'h0b00, 8'h04, 32'h06},
		'{1'b1, 8'h08, 32'h01, 8'h40, 32'h03},
		'{1'b1, 8'h00, 32'h0d00, 8'h04, 32'h07},
		'{1'b0, 8'h00, 32'h0, 8'h08, 32'h00},
		'{1'b1, 8'h00, 32'h1000, 8'h40, 32'h01},
		'{1'b0, 8'h00, 32'h0, 8'h08, 32'h01},
		'{1'b1, 8'h00, 32'h0e00, 8'h40, 32'h80},
		'{1'b1, 8'h00, 32'h1100, 8'h04, 32'hc0},
		'{1'b0, 8'h00, 32'h0, 8'h08, 32'h00},
		'{1'b1, 8'h00, 32'h0f00, 8'h04, 32'h40},
		'{1'b1, 8'h00, 32'h0100, 8'h04, 32'h00},
		'{1'b1, 8'h00, 32'h0500, 8'h08, 32'h04},
		'{1'b1, 8'h00, 32'h0200, 8'h40, 32'h00},
		'{1'b1, 8'h04, 32'h0f, 8'h04, 32'h0f},
		'{1'b1, 8'h00, 32'h0600, 8'h40, 32'h0f},
		'{1'b0, 8'h00, 32'h0, 8'h08, 32'h00},
		'{1'b1, 8'h08, 32'h01, 8'h08, 32'h01},
		'{1'b1, 8'h00, 32'h1200, 8'h04, 32'h00},
		'{1'b0, 8'h00, 32'h0, 8'h08, 32'h07},
		'{1'b1, 8'h04, 32'h80, 8'h04, 32'h80},
		'{1'b1, 8'h00, 32'h1300, 8'h40, 32'h71},
		'{1'b0, 8'h00, 32'h0, 8'h08, 32'h09},
		'{1'b1, 8'h40, 32'h01, 8'h40, 32'h01},
		'{1'b1, 8'h00, 32'h1400, 8'h40, 32'h00},
		'{1'b0, 8'h00, 32'h0, 8'h08, 32'h09},
		'{1'b1, 8'h40, 32'h05, 8'h40, 32'h05},
		'{1'b1, 8'h00, 32'h0400, 8'h04, 32'h85},
		'{1'b1, 8'h00, 32'h0c00, 8'h40, 32'h0b},
		'{1'b0, 8'h00, 32'h0, 8'h08, 32'h08},
		'{1'b1, 8'h00, 32'h1f00, 8'h18, 32'h06}
	};
	mie_top i_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .acc(acc), .flags(flags),
		.pc(pc), .global_interrupt_enable(global_interrupt_enable));
	mie_apb_host i_host (.clk(clk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	// Clock at 50 MHz
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Verdict and end of run
	task automatic report_and_stop();
		if (n_errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One bus transfer; a wait that runs out ends the run
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		i_host.xfer(w, a, d, rdv, errv, ncyc);
		if (ncyc > 20) begin
			n_errors++;
			report_and_stop();
		end
	endtask
	// Reset, table of cases, then timing, returns, errors and reset
	initial begin
		rstn = 1'b0;
		n_errors = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].we) bus(1'b1, rows[i].wa, rows[i].wd);
			bus(1'b0, rows[i].ra, 32'h0);
			`CHK(rdv, rows[i].ex)
		end
		bus(1'b1, 8'h40, 32'h02);
		p = pc;
		bus(1'b1, OFS_INSTR, 32'h1400);
		`CHK({ncyc, pc}, {32'd3, p + 16'h0001})
		bus(1'b1, OFS_INSTR, 32'h1400);
		`CHK({ncyc, pc}, {32'd4, p + 16'h0003})
		bus(1'b1, OFS_INSTR, 32'h0300);
		`CHK({ncyc, pc}, {32'd3, p + 16'h0004})
		bus(1'b1, OFS_STACK, 32'h1234);
		bus(1'b1, OFS_INSTR, 32'h0700);
		`CHK({ncyc, pc}, {32'd4, 16'h1234})
		bus(1'b1, OFS_STACK, 32'h0055);
		bus(1'b1, OFS_INSTR, 32'h085a);
		`CHK({pc, acc}, 24'h00555a)
		bus(1'b1, OFS_STACK, 32'h0777);
		bus(1'b1, OFS_INSTR, 32'h0900);
		`CHK({global_interrupt_enable, pc}, 17'h10777)
		bus(1'b0, 8'h1c, 32'h0);
		`CHK({errv, rdv}, 33'h100000000)
		bus(1'b1, 8'h41, 32'h5);
		`CHK(errv, 1'b1)
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK({acc, flags, pc, global_interrupt_enable}, 31'h0)
		report_and_stop();
	end
endmodule
`default_nettype wire
